// ===== boot_cmd_engine.sv
// Purpose: single-boot command interpreter on a byte-serial link
// Assumes: receiver/transmitter and helpers run on CLK; inputs are same-clock
// Notes:   one byte per RX_VALID pulse; one byte per TX_VALID pulse
// Functional notes
// RQ1 - host selects uart with first byte 0x86
// RQ2 - host selects sync with 0x30, slow start
// RQ3 - receiver stays off during mode detection
// RQ4 - good baud: update divider, answer 0x86; else halt
// RQ5 - host waits five seconds for 0x86
// RQ6 - sync: shift clock input, answer 0x30
// RQ7 - receiver enabled before mode acknowledge loaded
// RQ8 - host sends command byte; 0x10 is ram transfer
// RQ9 - command receive error answers prior-high-nibble plus 8
// RQ10 - sync mode never reports receive errors
// RQ11 - valid command echoed; 0x10 starts password check
// RQ12 - unknown command answers prior-high-nibble plus 1
// RQ13 - twelve password bytes compared in order
// RQ14 - host sends two's complement password checksum
// RQ15 - receive error in password bytes answers 0x18
// RQ16 - nonzero password checksum answers 0x11
// RQ17 - uniform non-erased stored password or mismatch: 0x11
// RQ18 - all checks pass answers 0x10
// RQ19 - four address bytes, most significant first
// RQ20 - chip erase needs no password, sets security
// RQ21 - flash sum returned; no raw flash readback
// RQ22 - erase command 0x40 echoed on acceptance
// RQ23 - length bytes follow, high byte first
// RQ24 - acknowledge bits 1 and 2 always zero; the uart mode acknowledge 0x86 has both bits set
`default_nettype none
module boot_cmd_engine
(
    // clock and reset
    input  wire logic        CLK,
    input  wire logic        RST_N,
    // mode byte detector
    input  wire logic        MODE_VALID,
    input  wire logic [7:0]  MODE_BYTE,
    input  wire logic        BAUD_OK,
    input  wire logic [15:0] BAUD_MEAS,
    // serial receiver
    input  wire logic        RX_VALID,
    input  wire logic [7:0]  RX_DATA,
    input  wire logic        RX_ERR,
    // serial transmitter
    input  wire logic        TX_READY,
    output logic             TX_VALID,
    output logic [7:0]       TX_DATA,
    // serial channel configuration
    output logic             RX_ENABLE,
    output logic             SYNC_MODE,
    output logic             SCLK_INPUT,
    output logic [15:0]      BAUD_DIV,
    output logic             HALTED,
    // stored password, byte 0 in bits 7:0
    input  wire logic [95:0] PWD_STORED,
    // ram load address and length
    output logic [31:0]      LOAD_ADDR,
    output logic             ADDR_VALID,
    output logic [15:0]      LOAD_LEN,
    output logic             LEN_VALID,
    // flash erase and sum
    output logic             ERASE_REQ,
    input  wire logic        ERASE_DONE,
    output logic             SECURITY_BIT,
    output logic             SUM_REQ,
    input  wire logic        SUM_DONE,
    input  wire logic [15:0] SUM_VALUE
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        boot_pkg::state_t st;
        logic             rx_en;
        logic             sync;
        logic             sclk_in;
        logic [15:0]      baud;
        logic [3:0]       prev_hi;
        logic [3:0]       idx;
        logic [7:0]       psum;
        logic             perr;
        logic             rerr;
        logic [31:0]      addr;
        logic             addr_vld;
        logic             tx_vld;
        logic [7:0]       tx_data;
        logic             erase_req;
        logic             sum_req;
        logic             secure;
        logic [7:0]       sum_lo;
        logic [15:0]      len;
        logic             len_vld;
        logic             halt;
    } eng_t;

    eng_t q;
    eng_t d;

    // a stored password of one repeated non-erased value is too guessable
    function automatic logic uniform_pwd(input logic [95:0] p);
        logic same;
        same = 1'b1;
        for (int i = 1; i < 12; i++)
        begin
            if (p[i*8 +: 8] != p[7:0])
            begin
                same = 1'b0;
            end
        end
        return same && (p[7:0] != boot_pkg::ERASED_BYTE);
    endfunction : uniform_pwd

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic       rx_bad;
        logic [7:0] total;
        rx_bad = RX_ERR && !q.sync; // [RQ10]
        total  = 8'h00;
        d = q;
        d.tx_vld    = 1'b0;
        d.addr_vld  = 1'b0;
        d.erase_req = 1'b0;
        d.sum_req   = 1'b0;
        d.len_vld   = 1'b0;
        case (q.st)
            boot_pkg::ST_MODE:
            begin
                d.rx_en = 1'b0; // [RQ3]
                if (MODE_VALID && MODE_BYTE == boot_pkg::MODE_UART)
                begin
                    if (BAUD_OK)
                    begin
                        d.baud  = BAUD_MEAS; // [RQ4]
                        d.rx_en = 1'b1; // [RQ7]
                        d.st    = boot_pkg::ST_ACK1;
                    end
                    else
                    begin
                        d.halt = 1'b1;
                        d.st = boot_pkg::ST_HALT; // [RQ4]
                    end
                end
                else if (MODE_VALID && MODE_BYTE == boot_pkg::MODE_SYNC)
                begin
                    d.sync    = 1'b1;
                    d.sclk_in = 1'b1; // [RQ6]
                    d.rx_en   = 1'b1; // [RQ7]
                    d.st      = boot_pkg::ST_ACK1;
                end
            end
            boot_pkg::ST_ACK1:
            begin
                // receiver was enabled a cycle earlier
                if (TX_READY)
                begin
                    d.tx_vld  = 1'b1;
                    d.tx_data = q.sync ? boot_pkg::MODE_SYNC
                                       : boot_pkg::MODE_UART; // [RQ4] [RQ6]
                    d.st      = boot_pkg::ST_CMD;
                end
            end
            boot_pkg::ST_CMD:
            begin
                if (RX_VALID)
                begin
                    d.tx_vld = 1'b1;
                    if (rx_bad)
                    begin
                        d.tx_data = {q.prev_hi, boot_pkg::NIB_RXERR}; // [RQ9]
                    end
                    else if (RX_DATA == boot_pkg::CMD_RAM)
                    begin
                        d.tx_data = RX_DATA; // [RQ11]
                        d.prev_hi = RX_DATA[7:4];
                        d.idx     = 4'h0;
                        d.psum    = 8'h00;
                        d.perr    = 1'b0;
                        d.rerr    = 1'b0;
                        d.st      = boot_pkg::ST_PWD;
                    end
                    else if (RX_DATA == boot_pkg::CMD_ERASE)
                    begin
                        d.tx_data   = RX_DATA; // [RQ22]
                        d.prev_hi   = RX_DATA[7:4];
                        d.erase_req = 1'b1; // [RQ20]
                        d.st        = boot_pkg::ST_ERASE;
                    end
                    else if (RX_DATA == boot_pkg::CMD_SUM)
                    begin
                        d.tx_data = RX_DATA;
                        d.prev_hi = RX_DATA[7:4];
                        d.sum_req = 1'b1; // [RQ21]
                        d.st      = boot_pkg::ST_SUMW;
                    end
                    else
                    begin
                        d.tx_data = {q.prev_hi, boot_pkg::NIB_BADCMD}; // [RQ12]
                    end
                end
            end
            boot_pkg::ST_PWD:
            begin
                if (RX_VALID)
                begin
                    d.rerr = q.rerr | rx_bad;
                    if (q.idx != boot_pkg::CSUM_IDX)
                    begin
                        if (RX_DATA != PWD_STORED[q.idx*8 +: 8])
                        begin
                            d.perr = 1'b1; // [RQ13]
                        end
                        d.psum = q.psum + RX_DATA;
                        d.idx  = q.idx + 4'h1;
                    end
                    else
                    begin
                        total    = q.psum + RX_DATA; // [RQ16]
                        d.tx_vld = 1'b1;
                        d.idx    = 4'h0;
                        d.st     = boot_pkg::ST_CMD;
                        if (q.rerr || rx_bad)
                        begin
                            d.tx_data = boot_pkg::ACK_PW_RXE; // [RQ15]
                        end
                        else if (total != 8'h00)
                        begin
                            d.tx_data = boot_pkg::ACK_PW_BAD; // [RQ16]
                        end
                        else if (q.perr || uniform_pwd(PWD_STORED))
                        begin
                            d.tx_data = boot_pkg::ACK_PW_BAD; // [RQ17]
                        end
                        else
                        begin
                            d.tx_data = boot_pkg::ACK_PW_OK; // [RQ18]
                            d.st      = boot_pkg::ST_ADDR;
                        end
                    end
                end
            end
            boot_pkg::ST_ADDR:
            begin
                if (RX_VALID)
                begin
                    d.idx = q.idx + 4'h1;
                    if (!q.idx[2])
                    begin
                        d.addr = {q.addr[23:0], RX_DATA}; // [RQ19]
                    end
                    else
                    begin
                        d.len = {q.len[7:0], RX_DATA}; // [RQ23]
                    end
                    if (q.idx[1:0] == boot_pkg::ADDR_LAST)
                    begin
                        d.addr_vld = 1'b1;
                    end
                    if (q.idx == boot_pkg::LEN_LAST)
                    begin
                        // data and branch stages belong to the loader core
                        d.len_vld = 1'b1;
                        d.idx     = 4'h0;
                        d.st      = boot_pkg::ST_CMD;
                    end
                end
            end
            boot_pkg::ST_ERASE:
            begin
                if (ERASE_DONE)
                begin
                    d.secure = 1'b1; // [RQ20]
                    d.st     = boot_pkg::ST_CMD;
                end
            end
            boot_pkg::ST_SUMW:
            begin
                if (SUM_DONE && TX_READY)
                begin
                    d.tx_vld  = 1'b1;
                    d.tx_data = SUM_VALUE[15:8]; // [RQ21]
                    d.sum_lo  = SUM_VALUE[7:0];
                    d.st      = boot_pkg::ST_SUMLO;
                end
            end
            boot_pkg::ST_SUMLO:
            begin
                if (TX_READY)
                begin
                    d.tx_vld  = 1'b1;
                    d.tx_data = q.sum_lo;
                    d.st      = boot_pkg::ST_CMD;
                end
            end
            boot_pkg::ST_HALT:
            begin
                // unusable baud rate: stay silent until reset
                d.rx_en = 1'b0;
            end
            default:
            begin
                d.st = boot_pkg::ST_MODE;
            end
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            q         <= '0;
            q.st      <= boot_pkg::ST_MODE;
            q.baud    <= boot_pkg::BAUD_RESET;
            q.prev_hi <= boot_pkg::HI_RESET;
        end
        else
        begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign TX_VALID     = q.tx_vld;
    assign TX_DATA      = q.tx_data;
    assign RX_ENABLE    = q.rx_en;
    assign SYNC_MODE    = q.sync;
    assign SCLK_INPUT   = q.sclk_in;
    assign BAUD_DIV     = q.baud;
    assign HALTED       = q.halt;
    assign LOAD_ADDR    = q.addr;
    assign ADDR_VALID   = q.addr_vld;
    assign LOAD_LEN     = q.len;
    assign LEN_VALID    = q.len_vld;
    assign ERASE_REQ    = q.erase_req;
    assign SECURITY_BIT = q.secure;
    assign SUM_REQ      = q.sum_req;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_rx_off_mode: assert property ( // [RQ3]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_MODE) |-> !q.rx_en)
        else $error("receiver on during mode detection");

    chk_rxen_before_ack: assert property ( // [RQ7]
        @(posedge CLK) disable iff (!RST_N)
        (q.tx_vld && $past(q.st) == boot_pkg::ST_ACK1)
        |-> $past(q.rx_en) && q.rx_en)
        else $error("mode ack loaded before receiver enabled");

    chk_baud_update: assert property ( // [RQ4]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_MODE && MODE_VALID && BAUD_OK
         && MODE_BYTE == boot_pkg::MODE_UART)
        |=> q.baud == $past(BAUD_MEAS) ##[1:20] q.tx_vld
            && q.tx_data == boot_pkg::MODE_UART)
        else $error("baud not updated or 0x86 missing");

    chk_halt_silent: assert property ( // [RQ4]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_HALT) |=> !q.tx_vld && !q.rx_en)
        else $error("halted engine still active");

    chk_sync_noerr: assert property ( // [RQ10]
        @(posedge CLK) disable iff (!RST_N)
        (q.sync && q.tx_vld && $past(q.st) != boot_pkg::ST_SUMW
         && $past(q.st) != boot_pkg::ST_SUMLO) |-> !q.tx_data[3])
        else $error("receive error reported in sync mode");

    chk_ack_zero_bits: assert property ( // [RQ24]
        @(posedge CLK) disable iff (!RST_N)
        (q.tx_vld && q.st != boot_pkg::ST_SUMLO
         && $past(q.st) != boot_pkg::ST_SUMLO
         && $past(q.st) != boot_pkg::ST_ACK1
         && $past(q.st) != boot_pkg::ST_SUMW)
        |-> q.tx_data[2:1] == 2'b00)
        else $error("acknowledge bits 1 and 2 not zero");

    chk_ram_echo: assert property ( // [RQ11]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_CMD && RX_VALID && !(RX_ERR && !q.sync)
         && RX_DATA == boot_pkg::CMD_RAM)
        |=> q.tx_vld && q.tx_data == boot_pkg::CMD_RAM
            && q.st == boot_pkg::ST_PWD)
        else $error("ram transfer command not echoed");

    chk_bad_cmd: assert property ( // [RQ12]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_CMD && RX_VALID && !(RX_ERR && !q.sync)
         && RX_DATA != boot_pkg::CMD_RAM && RX_DATA != boot_pkg::CMD_ERASE
         && RX_DATA != boot_pkg::CMD_SUM)
        |=> q.tx_vld && q.tx_data == {$past(q.prev_hi), 4'h1}
            && q.st == boot_pkg::ST_CMD)
        else $error("invalid command answer wrong");

    chk_secure_set: assert property ( // [RQ20]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_ERASE && ERASE_DONE) |=> q.secure)
        else $error("security bit not set after erase");

    chk_len_done: assert property ( // [RQ23]
        @(posedge CLK) disable iff (!RST_N)
        (q.st == boot_pkg::ST_ADDR && RX_VALID
         && q.idx == boot_pkg::LEN_LAST)
        |=> q.len_vld && q.len[7:0] == $past(RX_DATA)
            && q.st == boot_pkg::ST_CMD)
        else $error("length stage not closed");

    chk_sclk_input: assert property ( // [RQ6]
        @(posedge CLK) disable iff (!RST_N)
        q.sync |-> q.sclk_in && q.rx_en)
        else $error("sync mode without clock input");
endmodule : boot_cmd_engine
`default_nettype wire

// ===== boot_pkg.sv
// Purpose: shared constants and state encoding for the boot command engine
// Assumes: byte-level serial receiver and transmitter on the same clock
// Notes:   codes are the link's own byte values
`default_nettype none
package boot_pkg;
    // ------------------------------------------------------------
    // link byte codes
    // ------------------------------------------------------------
    localparam logic [7:0] MODE_UART   = 8'h86;
    localparam logic [7:0] MODE_SYNC   = 8'h30;
    localparam logic [7:0] CMD_RAM     = 8'h10;
    localparam logic [7:0] CMD_ERASE   = 8'h40;
    localparam logic [7:0] CMD_SUM     = 8'h20;
    localparam logic [7:0] ACK_PW_OK   = 8'h10;
    localparam logic [7:0] ACK_PW_RXE  = 8'h18;
    localparam logic [7:0] ACK_PW_BAD  = 8'h11;
    localparam logic [3:0] NIB_RXERR   = 4'h8;
    localparam logic [3:0] NIB_BADCMD  = 4'h1;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    // ------------------------------------------------------------
    // counts and reset values
    // ------------------------------------------------------------
    localparam logic [3:0]  PWD_LAST   = 4'hb;
    localparam logic [3:0]  CSUM_IDX   = 4'hc;
    localparam logic [1:0]  ADDR_LAST  = 2'h3;
    localparam logic [3:0]  LEN_LAST   = 4'h5;
    localparam logic [3:0]  HI_RESET   = 4'h0;
    localparam logic [15:0] BAUD_RESET = 16'h0000;
    // ------------------------------------------------------------
    // engine states, one-hot
    // ------------------------------------------------------------
    typedef enum logic [8:0] {
        ST_MODE  = 9'h001,
        ST_ACK1  = 9'h002,
        ST_CMD   = 9'h004,
        ST_PWD   = 9'h008,
        ST_ADDR  = 9'h010,
        ST_ERASE = 9'h020,
        ST_SUMW  = 9'h040,
        ST_SUMLO = 9'h080,
        ST_HALT  = 9'h100
    } state_t;
endpackage : boot_pkg
`default_nettype wire

// ===== boot_host_model.sv
// Purpose: host side of the boot link plus flash helper responses
// Assumes: byte-level link on the engine clock
// Notes:   tx bytes are queued for the bench; ready stalls when slow
`default_nettype none
module boot_host_model
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // first byte detector side
    output logic             mv,
    output logic [7:0]       mb,
    output logic             bok,
    output logic [15:0]      bmeas,
    // link bytes
    output logic             rv,
    output logic [7:0]       rd,
    output logic             re,
    output logic             trdy,
    input  wire logic        tv,
    input  wire logic [7:0]  td,
    // flash helpers
    input  wire logic        ereq,
    output logic             edone,
    input  wire logic        sreq,
    output logic             sdone,
    output logic [15:0]      sval
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_q[$];
    logic       slow;
    int         ecnt;
    int         scnt;
    initial
    begin
        {mv, mb, bok, bmeas, rv, rd, re} = '0;
        {trdy, edone, sdone, sval, slow, ecnt, scnt} = '0;
    end
    // ready toggles when slow, so the engine must wait for it
    always @(posedge clk)
    begin
        if (rst_n && tv)
            tx_q.push_back(td);
        trdy <= slow ? ~trdy : 1'b1;
        edone <= (ecnt == 1);
        ecnt <= ereq ? 6 : ((ecnt > 0) ? ecnt - 1 : 0);
        sdone <= sreq ? 1'b0 : ((scnt == 1) ? 1'b1 : sdone);
        scnt <= sreq ? 4 : ((scnt > 0) ? scnt - 1 : 0);
    end
    // first byte; released mb and bmeas show the inverse of the last value, bok holds
    task automatic send_mode(input logic [7:0] b, input logic ok,
                             input logic [15:0] m);
        @(posedge clk);
        mv <= 1'b1;
        mb <= b;
        bok <= ok;
        bmeas <= m;
        @(posedge clk);
        mv <= 1'b0;
        mb <= ~b;
        bmeas <= ~m;
    endtask : send_mode
    task automatic send_byte(input logic [7:0] b, input logic e);
        @(posedge clk);
        rv <= 1'b1;
        rd <= b;
        re <= e;
        @(posedge clk);
        rv <= 1'b0;
        rd <= ~b;
        re <= 1'b0;
    endtask : send_byte
endmodule : boot_host_model
`default_nettype wire

// ===== tb.sv
// Purpose: self-checking bench for the boot command engine
// Assumes: host model answers erase and sum requests
// Notes:   random password trials from a fixed xorshift seed
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [95:0] pwd = '0;
    logic mv, bok, rv, re, trdy, tv, rxen, sync, sclk, halted;
    logic avalid, lvalid, ereq, edone, sec, sreq, sdone;
    logic [7:0] mb, rd, td;
    logic [15:0] bmeas, bdiv, sval, llen;
    logic [31:0] laddr;
    logic [31:0] rs = 32'h0000457a;
    int mismatches = 0;
    int checks = 0;
    boot_cmd_engine dut_u (.CLK(clk), .RST_N(rst_n), .MODE_VALID(mv),
        .MODE_BYTE(mb), .BAUD_OK(bok), .BAUD_MEAS(bmeas), .RX_VALID(rv),
        .RX_DATA(rd), .RX_ERR(re), .TX_READY(trdy), .TX_VALID(tv),
        .TX_DATA(td), .RX_ENABLE(rxen), .SYNC_MODE(sync),
        .SCLK_INPUT(sclk), .BAUD_DIV(bdiv), .HALTED(halted),
        .PWD_STORED(pwd), .LOAD_ADDR(laddr), .ADDR_VALID(avalid),
        .LOAD_LEN(llen), .LEN_VALID(lvalid),
        .ERASE_REQ(ereq), .ERASE_DONE(edone), .SECURITY_BIT(sec),
        .SUM_REQ(sreq), .SUM_DONE(sdone), .SUM_VALUE(sval));
    boot_host_model host_u (.clk(clk), .rst_n(rst_n), .mv(mv), .mb(mb),
        .bok(bok), .bmeas(bmeas), .rv(rv), .rd(rd), .re(re), .trdy(trdy),
        .tv(tv), .td(td), .ereq(ereq), .edone(edone), .sreq(sreq),
        .sdone(sdone), .sval(sval));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    initial
        forever #20 clk = ~clk;
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    function automatic logic [7:0] exp_ack(input logic e, input logic bs,
        input logic mm, input logic sm, input logic [95:0] st);
        logic uni;
        uni = (st == {12{st[7:0]}}) && (st[7:0] != 8'hff);
        if (e && !sm)
            return 8'h18;
        if (bs || mm || uni)
            return 8'h11;
        return 8'h10;
    endfunction : exp_ack
    task automatic chk(input string n, input logic [31:0] e,
                       input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out
    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        host_u.tx_q.delete();
    endtask : do_reset
    task automatic expect_tx(input logic [7:0] e);
        int n;
        n = 0;
        while (host_u.tx_q.size() == 0 && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        chk("tx byte", e, (n < 400) ? host_u.tx_q.pop_front() : 8'hxx);
    endtask : expect_tx
    task automatic quiet(input int n);
        repeat (n) @(posedge clk);
        chk("tx count", 0, host_u.tx_q.size());
    endtask : quiet
    task automatic wait_hi(ref logic s, input string n);
        int k;
        k = 0;
        while (s !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        chk(n, 1, s);
    endtask : wait_hi
    task automatic cmd(input logic [7:0] b, input logic e,
                       input logic [7:0] x);
        host_u.send_byte(b, e);
        expect_tx(x);
    endtask : cmd
    // one password pass; kind bit0 wrong byte, bit1 bad sum, bit2 rx error
    task automatic ram_trial(input logic [95:0] st, input int kind,
                             input logic sm);
        logic [7:0] b, s, x;
        logic [31:0] a;
        logic [15:0] ln;
        int bad, eix;
        pwd <= st;
        cmd(8'h10, 1'b0, 8'h10);
        s = 8'h00;
        a = rnd();
        ln = 16'(rnd());
        bad = kind[0] ? int'(rnd() % 12) : 99;
        eix = kind[2] ? int'(rnd() % 13) : 99;
        for (int k = 0; k < 13; k++)
        begin
            b = st[8*k +: 8] ^ ((k == bad) ? 8'h01 : 8'h00);
            if (k == 12)
                b = 8'h00 - s + {7'h00, kind[1]};
            s = s + b;
            host_u.send_byte(b, k == eix);
        end
        x = exp_ack(kind[2], kind[1], kind[0], sm, st);
        expect_tx(x);
        if (x == 8'h10)
        begin
            for (int k = 3; k >= 0; k--)
                host_u.send_byte(a[8*k +: 8], 1'b0);
            wait_hi(avalid, "addr valid");
            chk("load addr", a, laddr);
            for (int k = 1; k >= 0; k--)
                host_u.send_byte(ln[8*k +: 8], 1'b0);
            wait_hi(lvalid, "len valid");
            chk("load len", {16'h0000, ln}, {16'h0000, llen});
        end
    endtask : ram_trial
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        close_out();
    end
    initial
    begin
        logic [15:0] m;
        do_reset();
        chk("rx enable", 0, rxen);
        chk("security", 0, sec);
        host_u.send_mode(8'h86, 1'b0, 16'h0123);
        quiet(30);
        chk("halted", 1, halted);
        host_u.send_byte(8'h10, 1'b0);
        quiet(10);
        do_reset();
        host_u.send_mode(8'h30, 1'b0, 16'h0000);
        expect_tx(8'h30);
        chk("sync shift clock in", 3, {sync, sclk});
        chk("rx enable", 1, rxen);
        cmd(8'h55, 1'b1, 8'h01);
        for (int i = 0; i < 8; i++)
            ram_trial({rnd(), rnd(), rnd()}, i, 1'b1);
        do_reset();
        m = rnd();
        host_u.send_mode(8'h86, 1'b1, m);
        expect_tx(8'h86);
        chk("baud divider", m, bdiv);
        chk("rx enable", 1, rxen);
        cmd(8'h10, 1'b1, 8'h08);
        cmd(8'h77, 1'b0, 8'h01);
        cmd(8'h40, 1'b0, 8'h40);
        wait_hi(sec, "security");
        cmd(8'h9a, 1'b0, 8'h41);
        cmd(8'h40, 1'b1, 8'h48);
        host_u.sval <= 16'(rnd());
        host_u.slow <= 1'b1;
        cmd(8'h20, 1'b0, 8'h20);
        expect_tx(host_u.sval[15:8]);
        expect_tx(host_u.sval[7:0]);
        host_u.slow <= 1'b0;
        ram_trial({12{8'hff}}, 0, 1'b0);
        ram_trial({12{8'h5a}}, 0, 1'b0);
        for (int i = 0; i < 30; i++)
            ram_trial({rnd(), rnd(), rnd()}, int'(rnd() % 8), 1'b0);
        close_out();
    end
endmodule : tb
`default_nettype wire
